// >>> hdl/ilsrc_pkg.sv
/*
 * Constants for the init lock / supply error / soft reset control register.
 * Assumes a 10 MHz core clock and a serial front end that decodes commands.
 */
package ilsrc_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] LOCK_CTRL_ADDR = 8'h10;
    localparam logic [7:0] LOCK_CTRL_RST  = 8'h00;
    localparam int         LOCK_BIT       = 7;
    localparam int         SUP_DIS_BIT    = 3;
    localparam int         KEY_HI         = 1;
    localparam int         KEY_LO         = 0;
    localparam logic [1:0] KEY_ZERO       = 2'h0;
    localparam logic [7:0] KEY_MASK       = 8'h03;
    // key values as {bit1,bit0}
    localparam logic [1:0] KEY_FIRST      = 2'h0;
    localparam logic [1:0] KEY_SECOND     = 2'h3;
    localparam logic [1:0] KEY_THIRD      = 2'h2;

    // ==========================================================
    // supply monitor timing
    localparam int CLOCK_HZ     = 10_000_000;
    localparam int T_RCV_US     = 1000;
    localparam int RCV_CYCLES   = (T_RCV_US * (CLOCK_HZ / 1_000_000) < 1) ? 1 :
                                  T_RCV_US * (CLOCK_HZ / 1_000_000);
    localparam int TMR_W        = 16;
    localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ONE  = 16'h0001;

    // ==========================================================
    // error detection
    localparam int         EXT_BYTES  = 3;
    localparam int         IMG_BYTES  = EXT_BYTES + 1;
    localparam int         IDX_W      = 2;
    localparam logic [7:0] CRC_POLY   = 8'h07;
    localparam logic [7:0] CRC_SEED   = 8'hff;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_STEP1 = 2'b01,
        KEY_STEP2 = 2'b11
    } ilsrc_key_t;
endpackage

// >>> hdl/ilsrc_edc.sv
/*
 * Continuous error detection over the user writable register image.
 * Assumes the image is stable while enabled (writes are locked out then).
 */
`timescale 1ns/1ps
module ilsrc_edc (
    // clock and reset
    input  wire logic                            i_clock,
    input  wire logic                            i_nrst,
    // control and image
    input  wire logic                            i_enable,
    input  wire logic [ilsrc_pkg::IMG_BYTES*8-1:0] i_image,
    // result
    output logic                                 o_mismatch
);
    import ilsrc_pkg::*;

    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int b = 0; b < 8; b++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    logic [IDX_W-1:0] idx_reg;
    logic [7:0]       crc_reg;
    logic [7:0]       ref_reg;
    logic             ref_ok_reg;
    logic             mism_reg;

    wire logic [7:0] cur_byte = i_image[idx_reg*8 +: 8];
    wire logic [7:0] crc_next = crc_byte(crc_reg, cur_byte);
    wire logic       last     = (idx_reg == IDX_W'(IMG_BYTES - 1));

    // ==========================================================
    // one byte per clock; first complete pass becomes the reference
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            idx_reg    <= '0;
            crc_reg    <= CRC_SEED;
            ref_reg    <= CRC_SEED;
            ref_ok_reg <= 1'b0;
            mism_reg   <= 1'b0;
        end else if (!i_enable) begin
            idx_reg    <= '0;
            crc_reg    <= CRC_SEED;
            ref_ok_reg <= 1'b0;
            mism_reg   <= 1'b0;
        end else begin
            idx_reg    <= last ? '0 : idx_reg + 1'b1;
            crc_reg    <= last ? CRC_SEED : crc_next;
            mism_reg   <= last && ref_ok_reg && (crc_next != ref_reg);
            if (last && !ref_ok_reg) begin
                ref_reg    <= crc_next;
                ref_ok_reg <= 1'b1;
            end
        end
    end

    assign o_mismatch = mism_reg;
endmodule

// >>> hdl/ilsrc_top.sv
/*
 * Lock and reset control register with supply error reporting control.
 * Assumes the serial front end gives one-cycle access strobes and tells
 * this block when a response went out and when the supply status is read.
 */
`timescale 1ns/1ps
module ilsrc_top #(
    parameter int RCV_CYCLES = ilsrc_pkg::RCV_CYCLES
) (
    // clock and reset
    input  wire logic                              i_clock,
    input  wire logic                              i_nrst,
    // register access from the serial front end
    input  wire logic                              i_acc_wr,
    input  wire logic                              i_acc_rd,
    input  wire logic [7:0]                        i_acc_addr,
    input  wire logic [7:0]                        i_acc_wdata,
    input  wire logic                              i_mode_i2c,
    output logic                                   o_rsp_valid,
    output logic [7:0]                             o_rsp_data,
    output logic                                   o_i2c_nack,
    // response stream control
    input  wire logic                              i_rsp_done,
    output logic                                   o_rsp_mute,
    output logic                                   o_err_code_once,
    // supply monitor
    input  wire logic                              i_supply_fault,
    input  wire logic                              i_sup_stat_rd,
    output logic                                   o_supply_err,
    // user register image and its error flag
    input  wire logic [ilsrc_pkg::EXT_BYTES*8-1:0] i_user_image,
    input  wire logic                              i_rw_err_clr,
    output logic                                   o_rw_err,
    // lock effects
    output logic                                   o_init_lock,
    output logic                                   o_write_inhibit,
    input  wire logic                              i_selftest_req,
    output logic                                   o_selftest_go,
    output logic                                   o_selftest_refused,
    output logic                                   o_soft_reset
);
    import ilsrc_pkg::*;

    localparam logic [TMR_W-1:0] RCV_LOAD = TMR_W'(RCV_CYCLES);

    logic [7:0]       ctrl_reg;
    ilsrc_key_t       key_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic             sup_err_reg;
    logic             pend_reg;
    logic             rw_err_reg;
    logic             rsp_valid_reg;
    logic [7:0]       rsp_data_reg;
    logic             nack_reg;
    logic             mute_reg;
    logic             st_go_reg;
    logic             st_ref_reg;
    logic             srst_reg;
    logic             mism;

    // ==========================================================
    // access decode
    wire logic       hit       = (i_acc_addr == LOCK_CTRL_ADDR);
    wire logic       wr_hit    = i_acc_wr && hit;
    wire logic       rd_hit    = i_acc_rd && hit && !i_acc_wr;
    wire logic [1:0] wkey      = i_acc_wdata[KEY_HI:KEY_LO];
    wire logic       locked    = ctrl_reg[LOCK_BIT];
    wire logic       sup_dis   = ctrl_reg[SUP_DIS_BIT];
    wire logic       third_key = wr_hit && (key_reg == KEY_STEP2) && (wkey == KEY_THIRD);

    // while locked only the key field takes the written value
    wire logic [7:0] ctrl_wr   = locked ? ((ctrl_reg & ~KEY_MASK) | (i_acc_wdata & KEY_MASK))
                                        : i_acc_wdata;
    // once set the lock bit survives any write
    wire logic [7:0] ctrl_lock = ctrl_wr | (ctrl_reg & (8'h01 << LOCK_BIT));
    wire logic [7:0] ctrl_next = wr_hit ? ctrl_lock : ctrl_reg;

    // ==========================================================
    // reset key sequence
    ilsrc_key_t key_next;
    always_comb begin
        key_next = key_reg;
        if (rd_hit) begin
            key_next = KEY_IDLE;
        end else if (wr_hit) begin
            // a first-step key always restarts the sequence
            if (wkey == KEY_FIRST) begin
                key_next = KEY_STEP1;
            end else begin
                unique case (key_reg)
                    KEY_STEP1: key_next = (wkey == KEY_SECOND) ? KEY_STEP2 : KEY_IDLE;
                    KEY_STEP2: key_next = KEY_IDLE;
                    KEY_IDLE:  key_next = KEY_IDLE;
                    default:   key_next = KEY_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // supply monitor timer and error reporting
    wire logic tmr_zero   = (tmr_reg == TMR_ZERO);
    wire logic [TMR_W-1:0] tmr_next = i_supply_fault ? RCV_LOAD :
                                      tmr_zero ? TMR_ZERO : tmr_reg - TMR_ONE;
    wire logic tmr_expire = (tmr_reg == TMR_ONE) && !i_supply_fault;
    wire logic tx_err     = pend_reg && i_rsp_done;
    wire logic spi_clr    = sup_dis ? 1'b1 : (i_sup_stat_rd || tx_err);
    wire logic sup_clr    = tmr_zero && (i_mode_i2c ? i_sup_stat_rd : spi_clr);
    // a new fault wins over a clear in the same cycle
    wire logic sup_next   = i_supply_fault || (sup_err_reg && !sup_clr);
    // spi with reporting enabled owes exactly one error-code response
    wire logic pend_set   = tmr_expire && sup_err_reg && !sup_dis && !i_mode_i2c;
    wire logic pend_next  = pend_set || (pend_reg && !i_rsp_done);

    // ==========================================================
    // error detection over the locked image, keys masked out
    wire logic [IMG_BYTES*8-1:0] image = {i_user_image, ctrl_reg & ~KEY_MASK};

    ilsrc_edc u_edc (
        .i_clock    (i_clock),
        .i_nrst     (i_nrst),
        .i_enable   (locked),
        .i_image    (image),
        .o_mismatch (mism)
    );

    wire logic rw_err_next = mism || (rw_err_reg && !i_rw_err_clr);

    // ==========================================================
    // responses: new register value on write except the third key, key field zero on read
    wire logic       rsp_now  = (wr_hit && !third_key) || rd_hit;
    wire logic [7:0] rsp_val  = rd_hit ? (ctrl_reg & ~KEY_MASK) : ctrl_lock;

    // ==========================================================
    // registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg    <= LOCK_CTRL_RST;
            key_reg     <= KEY_IDLE;
            tmr_reg     <= TMR_ZERO;
            sup_err_reg <= 1'b0;
            pend_reg    <= 1'b0;
            rw_err_reg  <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            key_reg     <= key_next;
            tmr_reg     <= tmr_next;
            sup_err_reg <= sup_next;
            pend_reg    <= pend_next;
            rw_err_reg  <= rw_err_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= LOCK_CTRL_RST;
            nack_reg      <= 1'b0;
            srst_reg      <= 1'b0;
            mute_reg      <= 1'b0;
            st_go_reg     <= 1'b0;
            st_ref_reg    <= 1'b0;
        end else begin
            rsp_valid_reg <= rsp_now;
            rsp_data_reg  <= rsp_now ? rsp_val : rsp_data_reg;
            nack_reg      <= third_key && i_mode_i2c;
            srst_reg      <= third_key;
            mute_reg      <= (tmr_next != TMR_ZERO);
            st_go_reg     <= i_selftest_req && !locked;
            st_ref_reg    <= i_selftest_req && locked;
        end
    end

    assign o_rsp_valid        = rsp_valid_reg;
    assign o_rsp_data         = rsp_data_reg;
    assign o_i2c_nack         = nack_reg;
    assign o_rsp_mute         = mute_reg;
    assign o_err_code_once    = pend_reg;
    assign o_supply_err       = sup_err_reg;
    assign o_rw_err           = rw_err_reg;
    assign o_init_lock        = ctrl_reg[LOCK_BIT];
    assign o_write_inhibit    = ctrl_reg[LOCK_BIT];
    assign o_selftest_go      = st_go_reg;
    assign o_selftest_refused = st_ref_reg;
    assign o_soft_reset       = srst_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    lock_sticky_a: assert property (o_init_lock |=> o_init_lock)
        else $error("lock bit cleared without reset");
    locked_cfg_hold_a: assert property (locked && wr_hit |=> $stable(ctrl_reg[SUP_DIS_BIT]))
        else $error("config bit changed while locked");
    third_key_reset_a: assert property (third_key |=> o_soft_reset && !o_rsp_valid)
        else $error("third key write did not reset silently");
    key_order_a: assert property (wr_hit && wkey == KEY_THIRD && key_reg != KEY_STEP2
                                  |=> !o_soft_reset)
        else $error("reset without full key sequence");
    read_key_zero_a: assert property (rd_hit |=> o_rsp_valid && o_rsp_data[KEY_HI:KEY_LO] == KEY_ZERO
                                      && key_reg == KEY_IDLE)
        else $error("read did not clear key field");
    write_echo_a: assert property (wr_hit && !third_key
                                   |=> o_rsp_valid && o_rsp_data[KEY_HI:KEY_LO] == $past(wkey))
        else $error("write response lacks written keys");
    bad_key_cancel_a: assert property (wr_hit && key_reg == KEY_STEP1 && wkey == KEY_THIRD
                                       |=> key_reg == KEY_IDLE)
        else $error("wrong key kept the sequence");
    fault_mute_a: assert property (i_supply_fault |=> (o_rsp_mute && o_supply_err) [*2])
        else $error("fault did not mute responses");
    auto_clear_a: assert property (sup_dis && !i_mode_i2c && tmr_zero && !i_supply_fault
                                   |=> !o_supply_err)
        else $error("supply error not cleared at zero");
    selftest_block_a: assert property (locked && i_selftest_req
                                       |=> !o_selftest_go && o_selftest_refused)
        else $error("self-test started while locked");

    cover_reset_c: cover property (third_key ##1 o_soft_reset);
    cover_lock_c: cover property (!o_init_lock ##1 o_init_lock);
    cover_errcode_c: cover property (pend_set ##[1:20] tx_err);
endmodule

// >>> verification/ilsrc_host_model.sv
/*
 * Host controller model: issues single register accesses to 0x10.
 * Assumes the block answers on the same edge at which it takes the access.
 */
`timescale 1ns/1ps
module ilsrc_host_model (
    // clock and answer
    input  wire logic       i_clock,
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_data,
    // access request
    output logic            o_acc_wr,
    output logic            o_acc_rd,
    output logic [7:0]      o_acc_addr,
    output logic [7:0]      o_acc_wdata
);
    initial begin
        o_acc_wr    = 1'b0;
        o_acc_rd    = 1'b0;
        o_acc_addr  = 8'hef;
        o_acc_wdata = 8'h00;
    end
    // ==========================================================
    // access: held one edge; on release the strobes drop, the address parks at 0xef
    // and the data is inverted so stale data never looks valid
    task automatic access(input logic wr, input logic [7:0] d,
                          output logic v, output logic [7:0] q);
        @(posedge i_clock);
        o_acc_wr    <= wr;
        o_acc_rd    <= ~wr;
        o_acc_addr  <= 8'h10;
        o_acc_wdata <= d;
        @(posedge i_clock);
        o_acc_wr    <= 1'b0;
        o_acc_rd    <= 1'b0;
        o_acc_addr  <= 8'hef;
        o_acc_wdata <= ~d;
        #1;
        v = i_rsp_valid;
        q = i_rsp_data;
    endtask
endmodule

// >>> verification/ilsrc_top_tb_top.sv
/*
 * Self-checking bench for the lock and soft reset control register.
 * Assumes the host model drives the access port; after a soft reset the
 * bench resets the block itself through rst_dut.
 */
`timescale 1ns/1ps
module ilsrc_top_tb_top;
    import ilsrc_pkg::*;
    localparam int RCV = 8;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        mode = 1'b0, done = 1'b0, fault = 1'b0, stat_rd = 1'b0;
    logic        clr = 1'b0, st_req = 1'b0;
    logic [23:0] image = 24'h5a3c96;
    logic        wr, rd, rv, nack, mute, once, serr, rw_err, lock, inh;
    logic        st_go, st_ref, srst, v;
    logic [7:0]  addr, wdata, rdata, q;
    int          error_cnt = 0, checked = 0, cyc = 0;

    always #50 clock = ~clock;

    ilsrc_host_model ilsrc_host_model_inst (.i_clock(clock),
        .i_rsp_valid(rv), .i_rsp_data(rdata), .o_acc_wr(wr),
        .o_acc_rd(rd), .o_acc_addr(addr), .o_acc_wdata(wdata));

    ilsrc_top #(.RCV_CYCLES(RCV)) ilsrc_top_inst (.i_clock(clock),
        .i_nrst(nrst), .i_acc_wr(wr), .i_acc_rd(rd), .i_acc_addr(addr),
        .i_acc_wdata(wdata), .i_mode_i2c(mode), .o_rsp_valid(rv),
        .o_rsp_data(rdata), .o_i2c_nack(nack), .i_rsp_done(done),
        .o_rsp_mute(mute), .o_err_code_once(once),
        .i_supply_fault(fault), .i_sup_stat_rd(stat_rd),
        .o_supply_err(serr), .i_user_image(image), .i_rw_err_clr(clr),
        .o_rw_err(rw_err), .o_init_lock(lock), .o_write_inhibit(inh),
        .i_selftest_req(st_req), .o_selftest_go(st_go),
        .o_selftest_refused(st_ref), .o_soft_reset(srst));

    // ==========================================================
    // checks and verdict
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard: whole run is under two hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ==========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic rst_dut();
        @(posedge clock) nrst <= 1'b0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
    endtask

    task automatic wr_chk(input logic [7:0] d, input logic [7:0] exp);
        ilsrc_host_model_inst.access(1'b1, d, v, q);
        chk1(v, 1'b1);
        chk8(q, exp);
    endtask

    // first two key steps, each answered with the written value
    task automatic keys12();
        wr_chk(8'h00, 8'h00);
        wr_chk(8'h03, 8'h03);
    endtask

    // fault pulse, early clear ignored, wait for timer expiry
    task automatic supply_run();
        @(posedge clock) fault <= 1'b1;
        @(posedge clock) fault <= 1'b0;
        stat_rd <= 1'b1;
        @(posedge clock) stat_rd <= 1'b0;
        #1;
        chk1(mute, 1'b1);
        chk1(serr, 1'b1);
        tick(RCV - 3);
        chk1(mute, 1'b1);
        for (int n = 0; n < 6 && mute !== 1'b0; n++) tick(1);
        chk1(mute, 1'b0);
    endtask

    // ==========================================================
    // scenarios
    initial begin
        rst_dut();
        wr_chk(8'h0b, 8'h0b);
        ilsrc_host_model_inst.access(1'b0, 8'h00, v, q);
        chk8(q, 8'h08);
        // read aborts a sequence in progress
        keys12();
        ilsrc_host_model_inst.access(1'b0, 8'h00, v, q);
        ilsrc_host_model_inst.access(1'b1, 8'h02, v, q);
        chk1(v, 1'b1);
        chk1(srst, 1'b0);
        // out-of-order key cancels
        wr_chk(8'h00, 8'h00);
        wr_chk(8'h02, 8'h02);
        chk1(srst, 1'b0);
        // full sequence, SPI then I2C
        for (int m = 0; m < 2; m++) begin
            mode <= m[0];
            keys12();
            ilsrc_host_model_inst.access(1'b1, 8'h02, v, q);
            chk1(v, 1'b0);
            chk1(srst, 1'b1);
            chk1(nack, m[0]);
            rst_dut();
        end
        // I2C: no one-shot code, cleared by status read
        supply_run();
        chk1(once, 1'b0);
        chk1(serr, 1'b1);
        @(posedge clock) stat_rd <= 1'b1;
        @(posedge clock) stat_rd <= 1'b0;
        tick(1);
        chk1(serr, 1'b0);
        mode <= 1'b0;
        // SPI, reporting enabled: one error-code response
        supply_run();
        chk1(once, 1'b1);
        chk1(serr, 1'b1);
        @(posedge clock) done <= 1'b1;
        @(posedge clock) done <= 1'b0;
        tick(1);
        chk1(serr, 1'b0);
        chk1(once, 1'b0);
        // SPI, reporting disabled: automatic clear
        wr_chk(8'h08, 8'h08);
        supply_run();
        tick(1);
        chk1(serr, 1'b0);
        chk1(once, 1'b0);
        // self-test, lock and error detection
        @(posedge clock) st_req <= 1'b1;
        @(posedge clock) st_req <= 1'b0;
        #1;
        chk1(st_go, 1'b1);
        wr_chk(8'h80, 8'h80);
        chk1(lock, 1'b1);
        chk1(inh, 1'b1);
        wr_chk(8'h4b, 8'h83);
        wr_chk(8'h00, 8'h80);
        @(posedge clock) st_req <= 1'b1;
        @(posedge clock) st_req <= 1'b0;
        #1;
        chk1(st_ref, 1'b1);
        chk1(st_go, 1'b0);
        tick(12);
        wr_chk(8'h03, 8'h83);
        tick(12);
        chk1(rw_err, 1'b0);
        @(posedge clock) image <= 24'h5a3c97;
        tick(14);
        chk1(rw_err, 1'b1);
        @(posedge clock) image <= 24'h5a3c96;
        tick(14);
        @(posedge clock) clr <= 1'b1;
        @(posedge clock) clr <= 1'b0;
        tick(2);
        chk1(rw_err, 1'b0);
        print_verdict();
    end
endmodule
